// File: core/pidr_regulator.v
// Process regulator: lowpass-filtered PID law turning setpoint and feedback into a frequency.
// Assumes an APB master with 32-bit data, one clock MCLK and an asynchronous high RESET.
//
// Decided for this implementation: the APB slave port and the address map.
`include "pidr_regs.vh"

module pidr_regulator #(
   parameter TS_CYC = `PIDR_TS_CYC
) (
   input  wire        MCLK,
   input  wire        RESET,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   output reg  [15:0] FREQ_OUT
);
   reg  [4:0]  ctrl_q;
   reg  [15:0] kp_q;
   reg  [15:0] td_q;
   reg  [15:0] kdcap_q;
   reg  [15:0] tf_q;
   reg  [15:0] setpt_q;
   reg  [15:0] fb_q;
   reg  [15:0] fmin_q;
   reg  [15:0] fmax_q;
   reg  [15:0] entry_q;
   reg  [19:0] ti_q;
   reg  [31:0] tick_q;
   reg         closed_q;
   reg         hold_q;
   reg         sgn_q;
   reg  signed [47:0] fbf_q;
   reg  signed [47:0] integ_q;
   reg  signed [31:0] dprev_q;
   reg  signed [31:0] err_prev_q;
   wire        access = PSEL & PENABLE & PREADY;
   wire        mapped = (PADDR[11:2] <= 10'd12) && (PADDR[1:0] == 2'b00);
   wire        tick = (tick_q == 32'd0);
   reg  [31:0] rd;

   // Read mux over the word registers
   always @* begin
      rd = 32'h0000_0000;
      case (PADDR)
         `PIDR_CTRL:     rd = {27'h0, ctrl_q};
         `PIDR_KP:       rd = {16'h0, kp_q};
         `PIDR_TI:       rd = {12'h0, ti_q};
         `PIDR_TD:       rd = {16'h0, td_q};
         `PIDR_KDCAP:    rd = {16'h0, kdcap_q};
         `PIDR_TF:       rd = {16'h0, tf_q};
         `PIDR_SETPOINT: rd = {16'h0, setpt_q};
         `PIDR_FEEDBACK: rd = {16'h0, fb_q};
         `PIDR_FMIN:     rd = {16'h0, fmin_q};
         `PIDR_FMAX:     rd = {16'h0, fmax_q};
         `PIDR_ENTRY:    rd = {16'h0, entry_q};
         `PIDR_FREQ:     rd = {16'h0, FREQ_OUT};
         `PIDR_STATUS:   rd = {29'h0, sgn_q, hold_q, closed_q};
         default:        rd = 32'h0000_0000;
      endcase
   end

   // APB slave: one wait state, PREADY high in the access cycle only
   // The wait state keeps the wide read mux off the path into PREADY
   always @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL & PENABLE & ~PREADY;
         PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
         PRDATA  <= (PSEL & PENABLE & ~PREADY & ~PWRITE) ? rd : 32'h0000_0000;
      end
   end

   // Register writes take effect at the completing edge
   always @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         ctrl_q  <= `PIDR_CTRL_RST;
         kp_q    <= `PIDR_KP_RST;
         ti_q    <= `PIDR_TI_RST;
         td_q    <= `PIDR_TD_RST;
         kdcap_q <= `PIDR_KDCAP_RST;
         tf_q    <= `PIDR_TF_RST;
         setpt_q <= 16'h0000;
         fb_q    <= 16'h0000;
         fmin_q  <= 16'h0000;
         fmax_q  <= `PIDR_FMAX_RST;
         entry_q <= 16'h0000;
      end else if (access && PWRITE) begin
         case (PADDR)
            `PIDR_CTRL:     ctrl_q  <= PWDATA[4:0];
            `PIDR_KP:       kp_q    <= (PWDATA[15:0] > 16'd1000) ? 16'd1000 : PWDATA[15:0];
            `PIDR_TI:       ti_q    <= (PWDATA[19:0] > 20'd999900) ? 20'd999900 : PWDATA[19:0];
            `PIDR_TD:       td_q    <= (PWDATA[15:0] > 16'd1000) ? 16'd1000 : PWDATA[15:0];
            `PIDR_KDCAP:    kdcap_q <= (PWDATA[15:0] < 16'd50) ? 16'd50 :
                                       (PWDATA[15:0] > 16'd500) ? 16'd500 : PWDATA[15:0];
            `PIDR_TF:       tf_q    <= (PWDATA[15:0] < 16'd1) ? 16'd1 :
                                       (PWDATA[15:0] > 16'd1000) ? 16'd1000 : PWDATA[15:0];
            `PIDR_SETPOINT: setpt_q <= PWDATA[15:0];
            `PIDR_FEEDBACK: fb_q    <= PWDATA[15:0];
            `PIDR_FMIN:     fmin_q  <= PWDATA[15:0];
            `PIDR_FMAX:     fmax_q  <= PWDATA[15:0];
            `PIDR_ENTRY:    entry_q <= PWDATA[15:0];
            default:        ;
         endcase
      end
   end

   // Reloads from zero, so the first tick falls on the first edge after reset
   // sample tick counter
   always @(posedge MCLK or posedge RESET) begin
      if (RESET)
         tick_q <= 32'd0;
      else
         tick_q <= tick ? TS_CYC - 1 : tick_q - 32'd1;
   end

   // Datapath: filter state keeps 16 fraction bits, error in whole units, gains x100
   // Times count sample periods; every term is signed so negative deviations survive
   reg  signed [47:0] fbf_d;
   reg  signed [47:0] p_term;
   reg  signed [47:0] i_step;
   reg  signed [47:0] d_raw;
   reg  signed [47:0] d_cap;
   reg  signed [47:0] sum;
   reg  signed [47:0] integ_d;
   reg  signed [31:0] err;
   reg  signed [31:0] d_d;
   reg  [15:0] freq_d;
   reg         at_lim;
   always @* begin
      // lowpass y += (x - y) / T
      // break at 1/T
      // Signed difference, so a falling feedback does not wrap into a huge step
      fbf_d = fbf_q + (($signed({16'h0, fb_q, 16'h0}) - fbf_q) / $signed({32'h0, tf_q}));
      err = ctrl_q[`PIDR_CTRL_INV] ? fbf_q[47:16] - {16'h0, setpt_q} :
                                     {16'h0, setpt_q} - fbf_q[47:16];
      p_term = ($signed({16'h0, kp_q}) * err) / 100;
      // integral step Kp*e/Ti per sample, Ti=0 treated as off
      i_step = (ti_q == 20'd0) ? 48'sd0 : p_term / $signed({28'h0, ti_q});
      d_raw = ($signed({16'h0, kp_q}) * (err - err_prev_q) * $signed({32'h0, td_q})) / 100;
      // gain cap: first-order roll-off closing kdcap_q/500 of the gap per sample, independent of Td
      d_cap = (td_q == 16'd0) ? 48'sd0 :
              dprev_q + ((d_raw * $signed({32'h0, kdcap_q}) / ($signed({32'h0, td_q}) * 10))
                         - dprev_q) * $signed({32'h0, kdcap_q}) / 500;
      d_d = d_cap[31:0];
      sum = p_term + integ_q + d_cap;
      at_lim = (sum < $signed({32'h0, fmin_q})) || (sum > $signed({32'h0, fmax_q}));
      freq_d = at_lim ? ((sum < $signed({32'h0, fmin_q})) ? fmin_q : fmax_q) : sum[15:0];
      integ_d = integ_q + i_step;
   end

   // Loop state, sampled on the tick
   // The integrator loads the demand when the loop closes, so the hand-over is bumpless
   always @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         fbf_q      <= 48'sd0;
         integ_q    <= 48'sd0;
         dprev_q    <= 32'sd0;
         err_prev_q <= 32'sd0;
         closed_q   <= 1'b0;
         hold_q     <= 1'b0;
         sgn_q      <= 1'b0;
         FREQ_OUT   <= 16'h0000;
      end else if (tick) begin
         fbf_q <= fbf_d;
         if (!ctrl_q[`PIDR_CTRL_START]) begin
            closed_q <= 1'b0;
            FREQ_OUT <= 16'h0000;
            integ_q  <= 48'sd0;
         // open-loop ramp until entry frequency in either mode while LIMIT is clear; the loop closes only when CLOSED is set
         end else if (!ctrl_q[`PIDR_CTRL_CLOSED] || !closed_q) begin
            if (FREQ_OUT >= entry_q) begin
               closed_q <= ctrl_q[`PIDR_CTRL_CLOSED];
               integ_q  <= {32'h0, FREQ_OUT};
            end else if (!ctrl_q[`PIDR_CTRL_LIMIT]) begin
               FREQ_OUT <= FREQ_OUT + 16'd1;
            end
         end else begin
            FREQ_OUT   <= freq_d;
            err_prev_q <= err;
            dprev_q    <= d_d;
            sgn_q      <= err[31];
            if (ctrl_q[`PIDR_CTRL_HOLD] && (at_lim || ctrl_q[`PIDR_CTRL_LIMIT])) begin
               hold_q  <= 1'b1;
               integ_q <= {32'h0, freq_d} - p_term - d_cap;
            end else if (hold_q && (err == 32'sd0 || err[31] != sgn_q)) begin
               hold_q  <= 1'b0;
               integ_q <= integ_d;
            end else if (!hold_q) begin
               integ_q <= integ_d;
            end
         end
      end
   end
endmodule // pidr_regulator

// File: shared/pidr_regs.vh
// Register map, field layouts, reset values and timing counts of the process regulator.
// Assumes a 32-bit APB master on a 200 MHz clock; every value is a `define.
`ifndef PIDR_REGS_VH
`define PIDR_REGS_VH
// Byte addresses of the word registers
`define PIDR_CTRL        12'h000
`define PIDR_KP          12'h004
`define PIDR_TI          12'h008
`define PIDR_TD          12'h00c
`define PIDR_KDCAP       12'h010
`define PIDR_TF          12'h014
`define PIDR_SETPOINT    12'h018
`define PIDR_FEEDBACK    12'h01c
`define PIDR_FMIN        12'h020
`define PIDR_FMAX        12'h024
`define PIDR_ENTRY       12'h028
`define PIDR_FREQ        12'h02c
`define PIDR_STATUS      12'h030
// Control bit positions
`define PIDR_CTRL_CLOSED 0
`define PIDR_CTRL_INV    1
`define PIDR_CTRL_HOLD   2
`define PIDR_CTRL_START  3
`define PIDR_CTRL_LIMIT  4
// Reset values: gains x100, times in 10 ms units, cap x10, frequencies in 0.01 Hz
`define PIDR_KP_RST      16'h0001
`define PIDR_TI_RST      20'h00064
`define PIDR_TD_RST      16'h0000
`define PIDR_KDCAP_RST   16'h0032
`define PIDR_TF_RST      16'h0001
`define PIDR_CTRL_RST    5'h04
`define PIDR_FMAX_RST    16'h1388
// Sample period: 10 ms at 200 MHz, 5 ns per cycle
`define PIDR_TS_NS       10000000
`define PIDR_CLK_NS      5
`define PIDR_TS_CYC      (`PIDR_TS_NS / `PIDR_CLK_NS)
`endif

// File: test/pidr_properties.sv
// Checker of the regulator's bus answers and demand update pacing.
// Assumes it is bound to pidr_regulator with a sample period of 4 or more.
module pidr_properties #(
   parameter int TS_CYC = 4
) (
   input wire logic        MCLK,
   input wire logic        RESET,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic [15:0] FREQ_OUT
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RESET);
   // One wait state, then a single-cycle answer
   a_ready_wait: assert property ($rose(PENABLE) && PSEL |=> PREADY) else $error("late answer");
   a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("long answer");
   a_ready_idle: assert property (!PSEL |=> !PREADY) else $error("answer unselected");
   // Unmapped or unaligned places are refused, never mapped ones
   a_err_place: assert property (PREADY |-> PSLVERR == (PADDR > 12'h030 || PADDR[1:0] != 2'b00))
      else $error("wrong refusal");
   a_err_alone: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0) else $error("bad error");
   a_data_idle: assert property (!PREADY |-> PRDATA == 32'h0) else $error("stray data");
   a_data_upper: assert property (PREADY && !PWRITE |-> PRDATA[31:20] == 12'h000)
      else $error("upper bits set");
   a_freq_pace: assert property ($changed(FREQ_OUT) |=> $stable(FREQ_OUT) [*3])
      else $error("demand moved between ticks");
   c_write: cover property (PREADY && PWRITE);
   c_refused: cover property (PSLVERR && !PWRITE);
   c_freq_move: cover property ($changed(FREQ_OUT));
endmodule // pidr_properties

// File: test/pidr_plant.sv
// Process model: the measured level lags the frequency demand.
// Assumes the regulator's clock and active-high reset.
module pidr_plant (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] freq,
   output logic      [15:0] level
);
   timeunit 1ns;
   timeprecision 100ps;
   // First-order lag: an eighth of the gap per cycle, so it never overshoots
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         level <= 16'h0000;
      end else begin
         level <= level + 16'($signed(freq - level) >>> 3);
      end
   end
endmodule // pidr_plant

// File: test/test_pid_process_regulator.sv
// Bench of the process regulator: resets, refusals, ramp, action and clamps.
// Assumes pidr_regulator, its header, the plant model and the checker.
`include "pidr_regs.vh"
`define PIDR_CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module test_pid_process_regulator;
   timeunit 1ns;
   timeprecision 100ps;
   logic        MCLK = 1'b0;
   logic        RESET = 1'b1;
   logic        PSEL = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic        PREADY;
   logic        PSLVERR;
   logic [15:0] FREQ_OUT;
   logic [15:0] level;
   logic [31:0] rd;
   logic        er;
   int          mismatches = 0;
   int          check_count = 0;
   always #2.5 MCLK = ~MCLK;
   // Short sample period keeps the run brief
   pidr_regulator #(.TS_CYC(4)) dut_u (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .FREQ_OUT(FREQ_OUT));
   pidr_plant plant_u (.clk(MCLK), .rst(RESET), .freq(FREQ_OUT), .level(level));
   // Bus transfer: hold until PREADY is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      // Wait as long as the slave needs; only the watchdog ends a hang
      do begin
         @(posedge MCLK);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic t_reset_vals();
      logic [11:0] ad [5] = '{`PIDR_KP, `PIDR_TD, `PIDR_KDCAP, `PIDR_TF, `PIDR_CTRL};
      logic [31:0] ex [5] = '{32'h1, 32'h0, 32'h32, 32'h1, 32'h4};
      foreach (ad[i]) begin
         apb(1'b0, ad[i], 32'h0);
         `PIDR_CHK(rd, ex[i])
      end
   endtask
   task automatic t_limits();
      apb(1'b1, `PIDR_KP, 32'h7d0);
      apb(1'b0, `PIDR_KP, 32'h0);
      `PIDR_CHK(rd, 32'h3e8)
      apb(1'b1, `PIDR_TD, 32'h7d0);
      apb(1'b0, `PIDR_TD, 32'h0);
      `PIDR_CHK(rd, 32'h3e8)
      apb(1'b1, 12'h006, 32'h5);
      `PIDR_CHK(er, 1'b1)
      apb(1'b0, 12'h034, 32'h0);
      `PIDR_CHK({er, rd}, {1'b1, 32'h0})
      apb(1'b0, `PIDR_KP, 32'h0);
      `PIDR_CHK(rd, 32'h3e8)
   endtask
   task automatic t_ramp();
      `PIDR_CHK(FREQ_OUT, 16'h0000)
      apb(1'b1, `PIDR_ENTRY, 32'h3);
      // Drive held at a limit: no ramp, the loop stays open
      apb(1'b1, `PIDR_CTRL, 32'h1c);
      repeat (20) @(posedge MCLK);
      `PIDR_CHK(FREQ_OUT, 16'h0000)
      apb(1'b1, `PIDR_CTRL, 32'hc);
      repeat (60) @(posedge MCLK);
      `PIDR_CHK(FREQ_OUT, 16'h0003)
      apb(1'b0, `PIDR_FREQ, 32'h0);
      `PIDR_CHK(rd, 32'h3)
   endtask
   task automatic t_action();
      logic [31:0] ctl [2] = '{32'hd, 32'hf};
      logic [15:0] lim [2] = '{16'h00c8, 16'h0320};
      apb(1'b1, `PIDR_FMIN, 32'hc8);
      apb(1'b1, `PIDR_FMAX, 32'h320);
      apb(1'b1, `PIDR_KP, 32'h64);
      apb(1'b1, `PIDR_TD, 32'h0);
      apb(1'b1, `PIDR_TI, 32'h64);
      apb(1'b1, `PIDR_SETPOINT, 32'h3e8);
      apb(1'b1, `PIDR_ENTRY, 32'h0);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, `PIDR_FEEDBACK, 32'(level) + 32'h5dc);
         apb(1'b1, `PIDR_CTRL, ctl[k]);
         repeat (400) @(posedge MCLK);
         `PIDR_CHK(FREQ_OUT, lim[k])
      end
      apb(1'b0, `PIDR_STATUS, 32'h0);
      `PIDR_CHK(rd, 32'h3)
   endtask
   task automatic complete_run();
      if (mismatches == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge MCLK);
      RESET <= 1'b0;
      t_reset_vals();
      t_limits();
      t_ramp();
      t_action();
      complete_run();
   end
   // Hang guard, well beyond the expected run
   initial begin
      #30000;
      mismatches++;
      complete_run();
   end
endmodule // test_pid_process_regulator
bind pidr_regulator pidr_properties #(.TS_CYC(TS_CYC)) chk_u (.MCLK(MCLK), .RESET(RESET),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FREQ_OUT(FREQ_OUT));
